// File: rtl/bio_map.svh
`ifndef BIO_MAP_SVH
`define BIO_MAP_SVH
// Register byte offsets on the Avalon-MM slave
`define BIO_OFS_PA_DATA 6'h00
`define BIO_OFS_PA_DIR 6'h04
`define BIO_OFS_PA_PULL 6'h08
`define BIO_OFS_PA_WAKE 6'h0c
`define BIO_OFS_PB_DATA 6'h10
`define BIO_OFS_PB_DIR 6'h14
`define BIO_OFS_PB_PULL 6'h18
`define BIO_OFS_PC_DATA 6'h1c
`define BIO_OFS_PC_DIR 6'h20
`define BIO_OFS_PC_PULL 6'h24
`define BIO_OFS_FUNC 6'h28
`define BIO_OFS_LCD 6'h2c
`define BIO_OFS_CONV 6'h30
`define BIO_OFS_STAT 6'h34
`define BIO_OFS_MASK 6'h38
// Reset values and implemented-bit masks
`define BIO_RST_ONES 8'hff
`define BIO_RST_ZERO 8'h00
`define BIO_ALL_MASK 8'hff
`define BIO_PB_MASK 8'h3f
`define BIO_PA_PU_MASK 8'h7f
`define BIO_LCD_MASK 8'h0f
`define BIO_CONV_MASK 8'h0f
`define BIO_FUNC_MASK 8'h03
`define BIO_IRQ_MASK 8'h03
// Field positions
`define BIO_FUNC_PFD 0
`define BIO_FUNC_PWM 1
`define BIO_STAT_WAKE 0
`define BIO_STAT_INT 1
`define BIO_PIN_INT 3
`define BIO_PIN_TMR 4
`define BIO_PIN_PFD 5
`define BIO_PIN_PWM 6
// Clock
`define BIO_CLK_PERIOD_NS 40
`endif

// File: rtl/bio_pkg.sv
package bio_pkg;
  // One port's pad drive, bit n drives pin n
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull;
  } bio_pad_t;
  typedef enum logic [1:0] {
    bio_tm_off = 2'b00,
    bio_tm_event = 2'b01,
    bio_tm_timer = 2'b10,
    bio_tm_capt = 2'b11
  } bio_tmode_t;
endpackage

// File: rtl/bio_sync.sv
`timescale 1ns/100ps
`default_nettype none
module bio_sync #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  // Idle high so reset never looks like a falling edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
      q <= '1;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= (s2 & s3) | (q & (s2 ^ s3));
    end
  end
endmodule
`default_nettype wire

// File: rtl/bio_port.sv
`timescale 1ns/100ps
`default_nettype none
module bio_port #(
  parameter logic [7:0] IMPL = 8'hff,
  parameter logic [7:0] PU_MASK = 8'hff
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] dir,
  input wire logic [7:0] latch,
  input wire logic [7:0] pull,
  input wire logic [7:0] analog,
  input wire logic [7:0] alt_en,
  input wire logic [7:0] alt_val,
  input wire logic [7:0] ovr_en,
  input wire logic [7:0] ovr_oe,
  input wire logic [7:0] ovr_out,
  output bio_pkg::bio_pad_t pad
);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // Unimplemented pins never show a high latch
      pad.out <= IMPL;
      pad.oe <= '0;
      pad.pull <= '0;
    end else begin
      // Alternate outputs only win while the pin is an output
      pad.out <= IMPL & ((ovr_en & ovr_out) | (~ovr_en & alt_en & ~dir & alt_val)
                 | (~ovr_en & ~(alt_en & ~dir) & latch));
      pad.oe <= IMPL & ((ovr_en & ovr_oe) | (~ovr_en & ~dir));
      pad.pull <= IMPL & PU_MASK & pull & dir & ~analog & ~ovr_en;
    end
  end
endmodule
`default_nettype wire

// File: rtl/bio_top.sv
// What this block does
// - Wake-enable bit arms wake on its pin
// - Direction one is input, zero is output
// - Pull-high bit connects the pin pull-up
// - Unimplemented register bits read as zero
// - Input pin data reads the pin level
// - Output pin data reads the latch
// - Interrupt pin feeds logic only as input
// - Timer pin feeds timer only as input in event and capture modes
// - Divider output drives pin only when output
// - PWM drives pin only when selected, output
// - Low port B pins become LCD commons
// - Analog channel forces the pull-up off
// - Reset sets data latches and directions high
// - Bit updates rewrite the whole port byte
// - Enabled port A falling edge wakes sleep
// - Pull-up only acts on input pins
// - Port A bit 7 has no pull-up
// - Latch holds until written again
`timescale 1ns/100ps
`default_nettype none
`include "bio_map.svh"
module bio_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] pa_pin_in,
  input wire logic [5:0] pb_pin_in,
  input wire logic [7:0] pc_pin_in,
  output bio_pkg::bio_pad_t pa_pad,
  output bio_pkg::bio_pad_t pb_pad,
  output bio_pkg::bio_pad_t pc_pad,
  input wire logic sleep,
  output logic wake_req,
  output logic int_pin,
  input wire bio_pkg::bio_tmode_t timer_mode,
  output logic timer_pin,
  input wire logic pfd_sig,
  input wire logic pwm_sig,
  input wire logic [3:0] lcd_com_level,
  input wire logic [3:0] lcd_com_full,
  output logic [3:0] pb_half_bias,
  output logic irq
);
  logic [7:0] pa_data;
  logic [7:0] pa_dir;
  logic [7:0] pa_pull;
  logic [7:0] pa_wake;
  logic [7:0] pb_data;
  logic [7:0] pb_dir;
  logic [7:0] pb_pull;
  logic [7:0] pc_data;
  logic [7:0] pc_dir;
  logic [7:0] pc_pull;
  logic [7:0] func;
  logic [7:0] lcd;
  logic [7:0] conv;
  logic [7:0] stat;
  logic [7:0] mask;
  logic [21:0] pins_sync;
  logic [7:0] pa_s;
  logic [7:0] pb_s;
  logic [7:0] pc_s;
  logic [7:0] pa_prev;
  logic [7:0] pa_fall;
  logic [7:0] rd_val;
  logic [7:0] wval;
  logic wr_go;
  logic wake_hit;
  logic int_fall;
  logic [7:0] alt_en;
  logic [7:0] alt_val;
  logic [7:0] next_stat;

  //////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  bio_sync #(
    .W(22)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d({pc_pin_in, pb_pin_in, pa_pin_in}),
    .q(pins_sync)
  );
  assign pa_s = pins_sync[7:0];
  assign pb_s = {2'b00, pins_sync[13:8]};
  assign pc_s = pins_sync[21:14];

  //////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle for every access
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    end
  end

  // Write takes effect at the edge that sees waitrequest low
  assign wr_go = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign wval = avs_writedata[7:0];

  // Data register read: pin level for inputs, latch for outputs
  function automatic logic [7:0] port_read(input logic [7:0] dir, input logic [7:0] pin,
                                           input logic [7:0] latch, input logic [7:0] impl);
    port_read = impl & ((dir & pin) | (~dir & latch));
  endfunction

  always_comb begin
    rd_val = 8'h00;
    if (avs_address == `BIO_OFS_PA_DATA) begin
      rd_val = port_read(pa_dir, pa_s, pa_data, `BIO_ALL_MASK);
    end else if (avs_address == `BIO_OFS_PA_DIR) begin
      rd_val = pa_dir;
    end else if (avs_address == `BIO_OFS_PA_PULL) begin
      rd_val = pa_pull;
    end else if (avs_address == `BIO_OFS_PA_WAKE) begin
      rd_val = pa_wake;
    end else if (avs_address == `BIO_OFS_PB_DATA) begin
      rd_val = port_read(pb_dir, pb_s, pb_data, `BIO_PB_MASK);
    end else if (avs_address == `BIO_OFS_PB_DIR) begin
      rd_val = pb_dir;
    end else if (avs_address == `BIO_OFS_PB_PULL) begin
      rd_val = pb_pull;
    end else if (avs_address == `BIO_OFS_PC_DATA) begin
      rd_val = port_read(pc_dir, pc_s, pc_data, `BIO_ALL_MASK);
    end else if (avs_address == `BIO_OFS_PC_DIR) begin
      rd_val = pc_dir;
    end else if (avs_address == `BIO_OFS_PC_PULL) begin
      rd_val = pc_pull;
    end else if (avs_address == `BIO_OFS_FUNC) begin
      rd_val = func;
    end else if (avs_address == `BIO_OFS_LCD) begin
      rd_val = lcd;
    end else if (avs_address == `BIO_OFS_CONV) begin
      rd_val = conv;
    end else if (avs_address == `BIO_OFS_STAT) begin
      rd_val = stat;
    end else if (avs_address == `BIO_OFS_MASK) begin
      rd_val = mask;
    end
  end

  // Read data is captured while waitrequest is still high
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & avs_waitrequest) begin
      avs_readdata <= {24'h00_0000, rd_val};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Port registers; a bit update from software arrives as a full byte
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pa_data <= `BIO_RST_ONES;
      pb_data <= `BIO_PB_MASK;
      pc_data <= `BIO_RST_ONES;
    end else if (wr_go) begin
      if (avs_address == `BIO_OFS_PA_DATA) begin
        pa_data <= wval;
      end else if (avs_address == `BIO_OFS_PB_DATA) begin
        pb_data <= wval & `BIO_PB_MASK;
      end else if (avs_address == `BIO_OFS_PC_DATA) begin
        pc_data <= wval;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pa_dir <= `BIO_RST_ONES;
      pb_dir <= `BIO_PB_MASK;
      pc_dir <= `BIO_RST_ONES;
    end else if (wr_go) begin
      if (avs_address == `BIO_OFS_PA_DIR) begin
        pa_dir <= wval;
      end else if (avs_address == `BIO_OFS_PB_DIR) begin
        pb_dir <= wval & `BIO_PB_MASK;
      end else if (avs_address == `BIO_OFS_PC_DIR) begin
        pc_dir <= wval;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pa_pull <= `BIO_RST_ZERO;
      pb_pull <= `BIO_RST_ZERO;
      pc_pull <= `BIO_RST_ZERO;
      pa_wake <= `BIO_RST_ZERO;
    end else if (wr_go) begin
      if (avs_address == `BIO_OFS_PA_PULL) begin
        pa_pull <= wval & `BIO_PA_PU_MASK;
      end else if (avs_address == `BIO_OFS_PB_PULL) begin
        pb_pull <= wval & `BIO_PB_MASK;
      end else if (avs_address == `BIO_OFS_PC_PULL) begin
        pc_pull <= wval;
      end else if (avs_address == `BIO_OFS_PA_WAKE) begin
        pa_wake <= wval;
      end
    end
  end

  // Pin-function selects and interrupt mask
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      func <= `BIO_RST_ZERO;
      lcd <= `BIO_RST_ZERO;
      conv <= `BIO_RST_ZERO;
      mask <= `BIO_RST_ZERO;
    end else if (wr_go) begin
      if (avs_address == `BIO_OFS_FUNC) begin
        func <= wval & `BIO_FUNC_MASK;
      end else if (avs_address == `BIO_OFS_LCD) begin
        lcd <= wval & `BIO_LCD_MASK;
      end else if (avs_address == `BIO_OFS_CONV) begin
        conv <= wval & `BIO_CONV_MASK;
      end else if (avs_address == `BIO_OFS_MASK) begin
        mask <= wval & `BIO_IRQ_MASK;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pad drivers
  always_comb begin
    alt_en = 8'h00;
    alt_val = 8'h00;
    alt_en[`BIO_PIN_PFD] = func[`BIO_FUNC_PFD];
    alt_val[`BIO_PIN_PFD] = pfd_sig;
    alt_en[`BIO_PIN_PWM] = func[`BIO_FUNC_PWM];
    alt_val[`BIO_PIN_PWM] = pwm_sig;
  end

  // Converter channels sit on the low four port A pins
  bio_port #(
    .IMPL(`BIO_ALL_MASK),
    .PU_MASK(`BIO_PA_PU_MASK)
  ) u_pa (
    .mclk(mclk),
    .rst(rst),
    .dir(pa_dir),
    .latch(pa_data),
    .pull(pa_pull),
    .analog(conv),
    .alt_en(alt_en),
    .alt_val(alt_val),
    .ovr_en(8'h00),
    .ovr_oe(8'h00),
    .ovr_out(8'h00),
    .pad(pa_pad)
  );

  bio_port #(
    .IMPL(`BIO_PB_MASK),
    .PU_MASK(`BIO_PB_MASK)
  ) u_pb (
    .mclk(mclk),
    .rst(rst),
    .dir(pb_dir),
    .latch(pb_data),
    .pull(pb_pull),
    .analog(8'h00),
    .alt_en(8'h00),
    .alt_val(8'h00),
    .ovr_en(lcd),
    .ovr_oe({4'h0, lcd_com_full}),
    .ovr_out({4'h0, lcd_com_level}),
    .pad(pb_pad)
  );

  bio_port #(
    .IMPL(`BIO_ALL_MASK),
    .PU_MASK(`BIO_ALL_MASK)
  ) u_pc (
    .mclk(mclk),
    .rst(rst),
    .dir(pc_dir),
    .latch(pc_data),
    .pull(pc_pull),
    .analog(8'h00),
    .alt_en(8'h00),
    .alt_val(8'h00),
    .ovr_en(8'h00),
    .ovr_oe(8'h00),
    .ovr_out(8'h00),
    .pad(pc_pad)
  );

  // A common that is not at full drive floats at mid-rail
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pb_half_bias <= 4'h0;
    end else begin
      pb_half_bias <= lcd[3:0] & ~lcd_com_full;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Peripheral inputs and wake-up
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pa_prev <= `BIO_RST_ONES;
    end else begin
      pa_prev <= pa_s;
    end
  end

  assign pa_fall = pa_prev & ~pa_s;
  assign wake_hit = sleep & |(pa_fall & pa_wake);
  assign int_fall = pa_dir[`BIO_PIN_INT] & pa_fall[`BIO_PIN_INT];

  // Idle levels are high so a gated pin never makes an edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      int_pin <= 1'b1;
      timer_pin <= 1'b1;
      wake_req <= 1'b0;
    end else begin
      int_pin <= ~pa_dir[`BIO_PIN_INT] | pa_s[`BIO_PIN_INT];
      timer_pin <= ~(pa_dir[`BIO_PIN_TMR] & ((timer_mode == bio_pkg::bio_tm_event)
                   | (timer_mode == bio_pkg::bio_tm_capt))) | pa_s[`BIO_PIN_TMR];
      wake_req <= wake_hit;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Sticky status, set wins over a write-one clear
  always_comb begin
    next_stat = stat;
    if (wr_go && avs_address == `BIO_OFS_STAT) begin
      next_stat = stat & ~wval;
    end
    next_stat[`BIO_STAT_WAKE] = next_stat[`BIO_STAT_WAKE] | wake_hit;
    next_stat[`BIO_STAT_INT] = next_stat[`BIO_STAT_INT] | int_fall;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stat <= `BIO_RST_ZERO;
      irq <= 1'b0;
    end else begin
      stat <= next_stat;
      irq <= |(next_stat & mask);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_wake_arm: assert property (wake_req |-> $past(sleep & |(pa_fall & pa_wake)))
    else $error("wake without armed falling edge");
  chk_wake_fire: assert property (wake_hit |=> wake_req)
    else $error("armed edge in sleep did not wake");
  chk_dir_oe: assert property (##1 pa_pad.oe == ~$past(pa_dir))
    else $error("port A enable does not follow direction");
  chk_pull_gate: assert property (##1 pa_pad.pull == ($past(pa_pull & pa_dir & ~conv) & `BIO_PA_PU_MASK))
    else $error("port A pull-up wrong");
  chk_unimpl_zero: assert property (avs_readdata[31:8] == 24'h00_0000 && !pa_pull[7] && pb_dir[7:6] == 2'b00)
    else $error("unimplemented bit not zero");
  chk_read_data: assert property ((avs_read && avs_waitrequest && avs_address == `BIO_OFS_PA_DATA)
    |=> avs_readdata[7:0] == $past((pa_dir & pa_s) | (~pa_dir & pa_data)))
    else $error("port A data read wrong");
  chk_int_gate: assert property (!pa_dir[`BIO_PIN_INT] |=> int_pin)
    else $error("interrupt pin fed while output");
  chk_tmr_gate: assert property ((timer_mode == bio_pkg::bio_tm_timer) |=> timer_pin)
    else $error("timer pin fed in timer mode");
  chk_pfd_drive: assert property ((func[`BIO_FUNC_PFD] && !pa_dir[`BIO_PIN_PFD])
    |=> pa_pad.out[`BIO_PIN_PFD] == $past(pfd_sig) && pa_pad.oe[`BIO_PIN_PFD])
    else $error("divider output not on pin");
  chk_pwm_input: assert property ((func[`BIO_FUNC_PWM] && pa_dir[`BIO_PIN_PWM])
    |=> !pa_pad.oe[`BIO_PIN_PWM])
    else $error("PWM drove an input pin");
  chk_lcd_drive: assert property (lcd[0] |=> pb_pad.oe[0] == $past(lcd_com_full[0]))
    else $error("common pin drive wrong");
  chk_latch_hold: assert property (!$past(wr_go && avs_address == `BIO_OFS_PA_DATA) |-> $stable(pa_data))
    else $error("latch changed without write");
  chk_bus_wait: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  cov_wake: cover property (wake_req);
  cov_pfd: cover property (func[`BIO_FUNC_PFD] && !pa_dir[`BIO_PIN_PFD]);
  cov_irq: cover property (irq);
  cov_lcd: cover property (lcd[0] && pb_half_bias[0]);
endmodule
`default_nettype wire

// File: dv/bio_board.sv
`timescale 1ns/100ps
`default_nettype none
// Pins and board: a strong outside driver beats the pad, then the pad, then the pull-up
module bio_board #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire bio_pkg::bio_pad_t pad,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [W-1:0] pin
);
  // A floating pin wanders every cycle so no level can pass by luck
  logic [7:0] flt = 8'h55;
  always @(posedge mclk) flt <= ~flt;
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin[i] = ext_en[i] ? ext_val[i] : pad.oe[i] ? pad.out[i] : pad.pull[i] ? 1'b1 : flt[i];
    end
  end
endmodule
`default_nettype wire

// File: dv/bidirectional_io_port_block_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "bio_map.svh"
module bidirectional_io_port_block_test;
  logic mclk, rst, avs_read, avs_write, avs_waitrequest, sleep, wake_req, int_pin, timer_pin, pfd_sig, pwm_sig, irq;
  logic [5:0] avs_address, pb_pin_in;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable, lcd_com_level, lcd_com_full, pb_half_bias;
  logic [7:0] pa_pin_in, pc_pin_in, ext_a, ext_a_en, ext_b, ext_c, r, q;
  bio_pkg::bio_pad_t pa_pad, pb_pad, pc_pad;
  bio_pkg::bio_tmode_t timer_mode;
  int fail_count = 0, tests_run = 0, wake_cnt = 0, c;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  bio_top i_bio_top (.mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .pa_pin_in, .pb_pin_in, .pc_pin_in, .pa_pad, .pb_pad, .pc_pad, .sleep,
    .wake_req, .int_pin, .timer_mode, .timer_pin, .pfd_sig, .pwm_sig, .lcd_com_level, .lcd_com_full,
    .pb_half_bias, .irq);
  bio_board #(.W(8)) i_bio_board_a (.mclk, .pad(pa_pad), .ext_val(ext_a), .ext_en(ext_a_en), .pin(pa_pin_in));
  bio_board #(.W(6)) i_bio_board_b (.mclk, .pad(pb_pad), .ext_val(ext_b), .ext_en(8'hff), .pin(pb_pin_in));
  bio_board #(.W(8)) i_bio_board_c (.mclk, .pad(pc_pad), .ext_val(ext_c), .ext_en(8'hff), .pin(pc_pin_in));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  task end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #(40 * 6000);
    fail_count++;
    end_of_test;
  end
  task chk(input string n, input logic [7:0] x, input logic [7:0] g);
    tests_run++;
    if (g !== x) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  // Read results are judged here, oldest note first; mask picks the bits that count
  always @(posedge mclk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      tests_run++;
      if (avs_readdata[31:8] !== 24'h0 || (avs_readdata[7:0] & e[15:8]) !== (e[7:0] & e[15:8])) begin
        fail_count++;
        $display("wrong value readdata expected %h seen %h", e[7:0] & e[15:8], avs_readdata & e[15:8]);
      end
    end
    if (wake_req === 1'b1) wake_cnt++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task bus(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] rq);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h0, d};
    // No cycle count assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    rq = avs_readdata[7:0];
    avs_read <= 0;
    avs_write <= 0;
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] t;
    bus(1, a, d, t);
  endtask
  task rd(input logic [5:0] a, input logic [7:0] x, input logic [7:0] m);
    logic [7:0] t;
    exp_q.push_back({m, x});
    bus(0, a, 8'h00, t);
  endtask
  task wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task done(input string s);
    $display("test %s done", s);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1; avs_address = 0; avs_read = 0; avs_write = 0; avs_writedata = 0; avs_byteenable = 4'h1;
    sleep = 0; timer_mode = bio_pkg::bio_tm_off; pfd_sig = 0; pwm_sig = 0; lcd_com_level = 0; lcd_com_full = 0;
    ext_a = 0; ext_a_en = 0; ext_b = 8'h2a; ext_c = 8'h81;
    void'($urandom(30));
    wt(2);
    rst <= 0;
    wt(2);
    rd(`BIO_OFS_PA_DIR, 8'hff, 8'hff);
    rd(`BIO_OFS_PB_DIR, 8'h3f, 8'hff);
    rd(`BIO_OFS_PC_DIR, 8'hff, 8'hff);
    rd(`BIO_OFS_PA_WAKE, 8'h00, 8'hff);
    rd(`BIO_OFS_PC_PULL, 8'h00, 8'hff);
    chk("pa oe", 8'h00, pa_pad.oe);
    chk("pa out", 8'hff, pa_pad.out);
    done("reset");
    wr(`BIO_OFS_PA_PULL, 8'hff);
    rd(`BIO_OFS_PA_PULL, 8'h7f, 8'hff);
    wr(`BIO_OFS_PB_DIR, 8'hff);
    rd(`BIO_OFS_PB_DIR, 8'h3f, 8'hff);
    rd(6'h3c, 8'h00, 8'hff);
    avs_byteenable <= 4'h0;
    wr(`BIO_OFS_PC_DIR, 8'h00);
    avs_byteenable <= 4'h1;
    rd(`BIO_OFS_PC_DIR, 8'hff, 8'hff);
    wr(`BIO_OFS_PA_PULL, 8'h00);
    done("bits");
    r = $urandom;
    ext_a <= r;
    ext_a_en <= 8'hff;
    wt(8);
    rd(`BIO_OFS_PA_DATA, r, 8'hff);
    wr(`BIO_OFS_PA_DIR, 8'h00);
    wt(3);
    chk("pa oe", 8'hff, pa_pad.oe);
    chk("pa out", 8'hff, pa_pad.out);
    wr(`BIO_OFS_PA_DATA, ~r);
    wr(`BIO_OFS_PB_DATA, r);
    wt(8);
    chk("pa out", ~r, pa_pad.out);
    rd(`BIO_OFS_PA_DATA, ~r, 8'hff);
    rd(`BIO_OFS_PB_DATA, 8'h2a, 8'hff);
    rd(`BIO_OFS_PC_DATA, 8'h81, 8'hff);
    wr(`BIO_OFS_PB_DIR, 8'h00);
    wt(3);
    chk("pb out", r & 8'h3f, pb_pad.out);
    rd(`BIO_OFS_PB_DATA, r & 8'h3f, 8'hff);
    wr(`BIO_OFS_PC_PULL, 8'h5a);
    wt(3);
    chk("pc pull", 8'h5a, pc_pad.pull);
    wr(`BIO_OFS_PC_PULL, 8'h00);
    done("data");
    wr(`BIO_OFS_PA_DIR, 8'hff);
    wr(`BIO_OFS_PA_PULL, 8'h3c);
    wt(3);
    chk("pa pull", 8'h3c, pa_pad.pull);
    wr(`BIO_OFS_CONV, 8'h0f);
    wt(3);
    chk("pa pull", 8'h30, pa_pad.pull);
    wr(`BIO_OFS_PA_DIR, 8'h0f);
    wt(3);
    chk("pa pull", 8'h00, pa_pad.pull);
    wr(`BIO_OFS_CONV, 8'h00);
    wr(`BIO_OFS_PA_PULL, 8'h00);
    done("pull");
    ext_a <= 8'ha0;
    ext_a_en <= 8'hf0;
    wr(`BIO_OFS_PA_DIR, 8'hf0);
    wr(`BIO_OFS_PA_DATA, 8'h05);
    wt(8);
    bus(0, `BIO_OFS_PA_DATA, 8'h00, q);
    q[1] = 1'b1;
    wr(`BIO_OFS_PA_DATA, q);
    ext_a_en <= 8'h00;
    wr(`BIO_OFS_PA_DIR, 8'h00);
    wt(3);
    chk("pa out", 8'ha7, pa_pad.out);
    done("modify");
    wr(`BIO_OFS_PA_DATA, 8'h00);
    wr(`BIO_OFS_PA_DIR, 8'h9f);
    pfd_sig <= 1;
    pwm_sig <= 1;
    wt(3);
    chk("pa out", 8'h00, pa_pad.out & 8'h60);
    wr(`BIO_OFS_FUNC, 8'h03);
    wt(3);
    chk("pa out", 8'h60, pa_pad.out & 8'h60);
    chk("pa oe", 8'h60, pa_pad.oe & 8'h60);
    pwm_sig <= 0;
    wt(3);
    chk("pa out", 8'h20, pa_pad.out & 8'h60);
    wr(`BIO_OFS_PA_DIR, 8'hff);
    wt(3);
    chk("pa oe", 8'h00, pa_pad.oe & 8'h60);
    wr(`BIO_OFS_FUNC, 8'h00);
    done("shared out");
    wr(`BIO_OFS_MASK, 8'h02);
    ext_a <= 8'hff;
    ext_a_en <= 8'hff;
    wt(8);
    wr(`BIO_OFS_STAT, 8'hff);
    ext_a <= 8'h00;
    wt(8);
    chk("int pin", 8'h00, {7'h0, int_pin});
    chk("irq", 8'h01, {7'h0, irq});
    rd(`BIO_OFS_PA_DATA, 8'h00, 8'hff);
    for (int m = 0; m < 4; m++) begin
      timer_mode <= bio_pkg::bio_tmode_t'(m);
      wt(3);
      chk("timer pin", (m == 1 || m == 3) ? 8'h00 : 8'h01, {7'h0, timer_pin});
    end
    wr(`BIO_OFS_PA_DIR, 8'he7);
    wt(4);
    chk("int pin", 8'h01, {7'h0, int_pin});
    chk("timer pin", 8'h01, {7'h0, timer_pin});
    done("shared in");
    wr(`BIO_OFS_PA_DIR, 8'hff);
    ext_a <= 8'hff;
    wr(`BIO_OFS_MASK, 8'h01);
    wr(`BIO_OFS_PA_WAKE, 8'h01);
    sleep <= 1;
    wt(8);
    wr(`BIO_OFS_STAT, 8'hff);
    c = wake_cnt;
    ext_a <= 8'hfd;
    wt(10);
    chk("wake count", 8'h00, 8'(wake_cnt - c));
    ext_a <= 8'hfc;
    wt(10);
    chk("wake count", 8'h01, 8'(wake_cnt - c));
    chk("irq", 8'h01, {7'h0, irq});
    rd(`BIO_OFS_STAT, 8'h01, 8'h01);
    wr(`BIO_OFS_STAT, 8'h01);
    wt(3);
    chk("irq", 8'h00, {7'h0, irq});
    rd(`BIO_OFS_STAT, 8'h00, 8'h01);
    ext_a <= 8'hff;
    wt(8);
    ext_a <= 8'hfe;
    wt(10);
    chk("irq", 8'h01, {7'h0, irq});
    wr(`BIO_OFS_MASK, 8'h00);
    wt(3);
    chk("irq", 8'h00, {7'h0, irq});
    sleep <= 0;
    done("wake");
    lcd_com_level <= 4'h5;
    wr(`BIO_OFS_LCD, 8'h0f);
    wt(3);
    chk("half bias", 8'h0f, {4'h0, pb_half_bias});
    lcd_com_full <= 4'hf;
    wt(3);
    chk("half bias", 8'h00, {4'h0, pb_half_bias});
    chk("pb oe", 8'h0f, pb_pad.oe & 8'h0f);
    chk("pb out", 8'h05, pb_pad.out & 8'h0f);
    chk("pb top", 8'h00, pb_pad.oe & 8'hc0);
    done("lcd");
    // Reset again in mid-run: latches, directions and selects return home
    rst <= 1;
    wt(2);
    rst <= 0;
    wt(2);
    chk("pb out", 8'h3f, pb_pad.out);
    chk("pb oe", 8'h00, pb_pad.oe);
    chk("half bias", 8'h00, {4'h0, pb_half_bias});
    rd(`BIO_OFS_LCD, 8'h00, 8'hff);
    rd(`BIO_OFS_PB_DIR, 8'h3f, 8'hff);
    done("reset again");
    wt(4);
    end_of_test;
  end
endmodule
`default_nettype wire
